// ### hdl/arfb_top.sv
// receive buffers, holding byte, rate feedback counter and register slave of the audio interface
`timescale 1ns/1ps
module arfb_top (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial link and frame pulse
  input  wire logic        sck,
  input  wire logic        word_select,
  input  wire logic        rx_sd,
  input  wire logic        sof_pulse,
  // interrupt
  output logic             irq
);
  // ***********************
  // state
  // ***********************
  arfb_pkg::arfb_mode0_t mode0;
  logic [7:0]            mode1;
  arfb_pkg::arfb_link_t  s1, s2, s3;
  arfb_pkg::arfb_rd_t    rd_state;
  logic [31:0]           sr, left_buf, right_buf, aligned, rd_val;
  logic [7:0]            hold;
  logic [5:0]            nbits, chan_w;
  logic                  started, chan_right, rx_en, sel_last;
  logic [15:0]           rate_cnt, rate_cap;
  logic [arfb_pkg::ST_W-1:0] status, mask, st_set, st_clr;
  logic                  aw_held, w_held, wr_do, rd_do, data_evt;
  logic [9:0]            aw_idx;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  sck_rise, sel_edge, sof_fall, src_edge, store_evt, rd_data;
  localparam logic [5:0] W32M = arfb_pkg::W_32;

  // ***********************
  // link synchroniser
  // ***********************
  // two stages before use; the third stage only feeds edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sel_last <= 1'b0;
    end else if (ce) begin
      s1 <= {sck, word_select, rx_sd, sof_pulse};
      s2 <= s1;
      s3 <= s2;
      if (sck_rise || !rx_en) sel_last <= s2.word_select; // select level as last seen at a bit clock edge
    end
  end

  // edges of the synchronised pins
  assign sck_rise = s2.sck & ~s3.sck;
  assign sel_edge = sck_rise & (s2.word_select != sel_last);
  assign sof_fall = s3.sof & ~s2.sof;
  assign src_edge = mode1[arfb_pkg::RATE_SRC_BIT] ? (s2.word_select & ~s3.word_select) : sck_rise;
  assign rx_en    = mode0.interface_on & mode0.rx_on;
  assign store_evt = sel_edge & started & rx_en;

  // ***********************
  // channel width and placement
  // ***********************
  // reserved code 10 behaves as 32 bits
  always_comb begin
    unique case ({mode0.slot_width_sel_hi, mode0.slot_width_sel_lo})
      arfb_pkg::CW_24: chan_w = arfb_pkg::W_24;
      arfb_pkg::CW_16: chan_w = arfb_pkg::W_16;
      default:         chan_w = arfb_pkg::W_32;
    endcase
  end

  // short words land per the justification bit
  always_comb begin
    if (mode0.rx_bit_order) begin
      aligned = mode0.rx_justify ? (sr << (chan_w - nbits)) : sr;
    end else begin
      aligned = mode0.rx_justify ? (sr >> (W32M - chan_w)) : (sr >> (W32M - nbits));
    end
    aligned = aligned & ~(32'hFFFFFFFF << chan_w);
  end
  // ***********************
  // receive shift register
  // ***********************
  // bits past the channel width are dropped rather than wrapping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr         <= '0;
      nbits      <= '0;
      started    <= 1'b0;
      chan_right <= 1'b0;
      left_buf   <= '0;
      right_buf  <= '0;
    end else if (ce) begin
      if (!rx_en) begin
        started    <= 1'b0;
        chan_right <= 1'b0;
        nbits      <= '0;
      end else if (sel_edge) begin
        started <= 1'b1;
        sr      <= mode0.rx_bit_order ? {31'h0, s2.sd} : {s2.sd, 31'h0};
        nbits   <= 6'h01;
        if (!started) begin
          chan_right <= 1'b0;
        end else begin
          chan_right <= ~chan_right;
          if (chan_right) begin
            right_buf <= aligned;
          end else begin
            left_buf <= aligned;
          end
        end
      end else if (sck_rise && started && nbits < chan_w) begin
        sr    <= mode0.rx_bit_order ? {sr[30:0], s2.sd} : {s2.sd, sr[31:1]};
        nbits <= nbits + 6'h01;
      end
    end
  end

  // ***********************
  // read pacing of the data buffer
  // ***********************
  // data returned by a read of the buffer address in each step
  always_comb begin
    rd_val = '0;
    unique case (rd_state)
      arfb_pkg::RD_L_LO: rd_val = {16'h0, left_buf[15:0]};
      arfb_pkg::RD_L_HI: rd_val = {16'h0, left_buf[31:16]};
      arfb_pkg::RD_R_LO: rd_val = (chan_w == arfb_pkg::W_24) ? {16'h0, right_buf[7:0], hold} : {16'h0, right_buf[15:0]};
      arfb_pkg::RD_R_HI: rd_val = (chan_w == arfb_pkg::W_24) ? {16'h0, right_buf[23:8]} : {16'h0, right_buf[31:16]};
      arfb_pkg::RD_IDLE, arfb_pkg::RD_HOLD: rd_val = '0;
    endcase
  end

  assign rd_data  = rd_do & (s_axi_araddr[11:2] == arfb_pkg::IDX_RXDATA);
  // a new request follows a store or a read that leaves more to fetch
  assign data_evt = store_evt | (rd_data & chan_w == arfb_pkg::W_32 & rd_state == arfb_pkg::RD_L_LO)
                  | (rd_data & chan_w != arfb_pkg::W_16 & rd_state == arfb_pkg::RD_R_LO);

  // a store beats a read in the same cycle, since the fresh word must be announced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= arfb_pkg::RD_IDLE;
      hold     <= '0;
    end else if (ce) begin
      if (!rx_en) begin
        rd_state <= arfb_pkg::RD_IDLE;
      end else if (store_evt) begin
        rd_state <= chan_right ? arfb_pkg::RD_R_LO : arfb_pkg::RD_L_LO;
      end else if (rd_data) begin
        unique case (rd_state)
          arfb_pkg::RD_L_LO: begin
            if (chan_w == arfb_pkg::W_24) begin
              hold     <= left_buf[23:16];
              rd_state <= arfb_pkg::RD_HOLD;
            end else begin
              rd_state <= (chan_w == arfb_pkg::W_32) ? arfb_pkg::RD_L_HI : arfb_pkg::RD_IDLE;
            end
          end
          arfb_pkg::RD_R_LO: rd_state <= (chan_w == arfb_pkg::W_16) ? arfb_pkg::RD_IDLE : arfb_pkg::RD_R_HI;
          arfb_pkg::RD_L_HI, arfb_pkg::RD_R_HI: rd_state <= arfb_pkg::RD_IDLE;
          arfb_pkg::RD_IDLE, arfb_pkg::RD_HOLD: rd_state <= rd_state;
        endcase
      end
    end
  end

  // ***********************
  // rate feedback
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_cnt <= '0;
      rate_cap <= '0;
    end else if (ce) begin
      if (sof_fall) begin
        rate_cap <= rate_cnt;
        rate_cnt <= {15'h0, src_edge & mode0.rate_count_on};
      end else if (mode0.rate_count_on && src_edge) begin
        rate_cnt <= rate_cnt + 16'h0001;
      end
    end
  end

  // ***********************
  // interrupt status
  // ***********************
  assign st_set = {sof_fall, store_evt & rd_state != arfb_pkg::RD_IDLE & rd_state != arfb_pkg::RD_HOLD, data_evt};
  assign st_clr = (wr_do && aw_idx == arfb_pkg::IDX_STATUS && w_strb[0]) ? w_data[arfb_pkg::ST_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else if (ce) begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  assign irq = |(status & mask);

  // ***********************
  // axi4-lite write
  // ***********************
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid & ce;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid & ce;
  assign wr_do         = aw_held & w_held & ~s_axi_bvalid;

  // address and data are taken in either order, then acted on together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= arfb_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx >= arfb_pkg::IDX_MODE0 && aw_idx <= arfb_pkg::IDX_MASK)
                        ? arfb_pkg::RESP_OKAY : arfb_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable registers; the capture register has no write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode0 <= arfb_pkg::MODE0_RST;
      mode1 <= arfb_pkg::MODE1_RST;
      mask  <= '0;
    end else if (ce && wr_do && w_strb[0]) begin
      if (aw_idx == arfb_pkg::IDX_MODE0) begin
        mode0 <= w_data[7:0];
      end
      if (aw_idx == arfb_pkg::IDX_MODE1) begin
        mode1 <= w_data[7:0];
      end
      if (aw_idx == arfb_pkg::IDX_MASK) begin
        mask <= w_data[arfb_pkg::ST_W-1:0];
      end
    end
  end

  // ***********************
  // axi4-lite read
  // ***********************
  assign s_axi_arready = ~s_axi_rvalid & ce;
  assign rd_do         = s_axi_arvalid & s_axi_arready;

  // data reads have a side effect, so each is taken once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= arfb_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_do) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= arfb_pkg::RESP_OKAY;
        unique case (s_axi_araddr[11:2])
          arfb_pkg::IDX_MODE0:   s_axi_rdata <= {24'h0, mode0};
          arfb_pkg::IDX_MODE1:   s_axi_rdata <= {24'h0, mode1};
          arfb_pkg::IDX_RXDATA:  s_axi_rdata <= rd_val;
          arfb_pkg::IDX_RATECAP: s_axi_rdata <= {16'h0, rate_cap};
          arfb_pkg::IDX_STATUS:  s_axi_rdata <= {29'h0, status};
          arfb_pkg::IDX_MASK:    s_axi_rdata <= {29'h0, mask};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= arfb_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***********************
  // checks
  // ***********************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_left_store_irq: assert property (ce && store_evt && !chan_right |=> rd_state == arfb_pkg::RD_L_LO && status[arfb_pkg::ST_DATA])
    else $error("left store did not request data");
  a_hold_capture: assert property (ce && rx_en && !store_evt && rd_data && rd_state == arfb_pkg::RD_L_LO
    && chan_w == arfb_pkg::W_24 |=> rd_state == arfb_pkg::RD_HOLD && hold == $past(left_buf[23:16]))
    else $error("24-bit first read did not park the top byte");
  a_hold_quiet: assert property (rd_state == arfb_pkg::RD_HOLD |-> !data_evt || store_evt)
    else $error("data request raised while byte parked");
  a_hold_release: assert property (ce && rx_en && rd_state == arfb_pkg::RD_HOLD && store_evt && chan_right
    |=> rd_state == arfb_pkg::RD_R_LO ##0 rd_val[7:0] == hold)
    else $error("parked byte not released with right word");
  a_sof_capture: assert property (ce && sof_fall |=> rate_cap == $past(rate_cnt))
    else $error("frame edge did not capture count");
  a_sof_clear: assert property (ce && sof_fall |=> rate_cnt <= 16'h0001)
    else $error("frame edge did not clear count");
  a_rate_gate: assert property (ce && !mode0.rate_count_on && !sof_fall |=> $stable(rate_cnt))
    else $error("rate counter moved while disabled");
  a_cap_readonly: assert property (ce && wr_do && aw_idx == arfb_pkg::IDX_RATECAP && !sof_fall |=> $stable(rate_cap))
    else $error("write changed capture register");
  a_rx_off_idle: assert property (ce && !rx_en |=> rd_state == arfb_pkg::RD_IDLE && !chan_right)
    else $error("receiver active while disabled");
  a_left_first: assert property (ce && rx_en && sel_edge && !started |=> started && !chan_right)
    else $error("first channel not left");
endmodule

// ### pkg/arfb_pkg.sv
// constants, register map and field types of the audio receive buffer and rate feedback block
// Notes on behaviour
// - A finished channel word landing in the left receive buffer raises the data interrupt.
// - In 24-bit mode a word read of the left buffer returns 16 bits and parks the other 8 in a holding byte.
// - While that byte is parked, no further data interrupt is raised for it.
// - The parked byte is handed out only after the right buffer is loaded, which raises the next interrupt.
// - A 16-bit counter counts bit-clock or word-select edges, and a 16-bit register keeps the captured count.
// - Each falling edge of the start-of-frame pulse copies the counter into the capture register.
// - The same start-of-frame edge restarts the counter at zero, or at one when a counted source edge falls in that cycle.
// - Reading the capture register gives the count of the frame before the latest start-of-frame.
// - Mode register 0 holds enables for the interface, transmitter and receiver, each active at 1.
// - The rate counter runs only while its own enable bit is 1.
// - Bits 5:4 pick the channel width: 00 is 32, 01 is 24, 11 is 16, 10 reserved.
// - The receive bit order is LSB first at 0 and MSB first at 1.
// - Short received words are LSB justified at 0 and MSB justified at 1.
// - The first channel word always goes to the left buffer, then buffers alternate at each word-select edge.
// - With fewer bit clocks than the channel width, received bits are placed per the justification bit.
package arfb_pkg;
  // ***********************
  // register indices (byte address is four times the index)
  // ***********************
  localparam logic [9:0] IDX_MODE0   = 10'h310;
  localparam logic [9:0] IDX_MODE1   = 10'h311;
  localparam logic [9:0] IDX_RXDATA  = 10'h312;
  localparam logic [9:0] IDX_RATECAP = 10'h313;
  localparam logic [9:0] IDX_STATUS  = 10'h314;
  localparam logic [9:0] IDX_MASK    = 10'h315;
  localparam logic [7:0] MODE0_RST   = 8'h00;
  localparam logic [7:0] MODE1_RST   = 8'h00;
  localparam int         RATE_SRC_BIT = 2;   // mode 1: 0 counts bit clock, 1 word select
  // ***********************
  // channel widths and status bits
  // ***********************
  localparam logic [1:0] CW_32 = 2'h0;
  localparam logic [1:0] CW_24 = 2'h1;
  localparam logic [1:0] CW_16 = 2'h3;
  localparam logic [5:0] W_32  = 6'h20;
  localparam logic [5:0] W_24  = 6'h18;
  localparam logic [5:0] W_16  = 6'h10;
  localparam int ST_DATA = 0;
  localparam int ST_OVR  = 1;
  localparam int ST_RATE = 2;
  localparam int ST_W    = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // mode register 0 layout, bit 7 first
  typedef struct packed {
    logic       rx_justify;
    logic       rx_bit_order;
    logic       slot_width_sel_hi;
    logic       slot_width_sel_lo;
    logic       rate_count_on;
    logic       rx_on;
    logic       tx_on;
    logic       interface_on;
  } arfb_mode0_t;
  // link pins after synchronising
  typedef struct packed {
    logic sck;
    logic word_select;
    logic sd;
    logic sof;
  } arfb_link_t;
  typedef enum logic [5:0] {
    RD_IDLE = 6'h01,
    RD_L_LO = 6'h02,
    RD_L_HI = 6'h04,
    RD_HOLD = 6'h08,
    RD_R_LO = 6'h10,
    RD_R_HI = 6'h20
  } arfb_rd_t;
endpackage

// ### bench/arfb_codec.sv
// behavioural audio codec driving bit clock, word select and serial data
`timescale 1ns/1ps
module arfb_codec (
  // serial link pins
  output logic sck,
  output logic word_select,
  output logic sd
);
  // ***********************
  // idle link
  // ***********************
  // clock stands still between frames
  initial begin
    sck         = 1'b0;
    word_select = 1'b1;
    sd          = 1'b0;
  end
  // one channel of n bits, data moved on the falling edge, word select flips with the first bit
  task automatic chan(input logic [31:0] d, input int n, input bit msb);
    for (int i = 0; i < n; i++) begin
      sd = msb ? d[n-1-i] : d[i];
      if (i == 0) word_select = ~word_select;
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    sd = ~sd;  // released line shows the inverse, never a stale bit
  endtask
  // a lone word select flip closes the channel under way
  task automatic close();
    word_select = ~word_select;
    sd = ~sd;
    #32 sck = 1'b1;
    #32 sck = 1'b0;
  endtask
  // n clock pulses, the first k of them with a word select pulse
  task automatic clocks(input int n, input int k);
    word_select = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i < k) word_select = 1'b1;
      #32 sck = 1'b1;
      #16 word_select = 1'b0;
      #16 sck = 1'b0;
    end
  endtask
endmodule

// ### bench/tb.sv
// self-checking bench of the audio receive buffer and rate feedback block
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] A_M0 = {arfb_pkg::IDX_MODE0, 2'h0};
  localparam logic [11:0] A_M1 = {arfb_pkg::IDX_MODE1, 2'h0};
  localparam logic [11:0] A_DAT = {arfb_pkg::IDX_RXDATA, 2'h0};
  localparam logic [11:0] A_CAP = {arfb_pkg::IDX_RATECAP, 2'h0};
  localparam logic [11:0] A_ST = {arfb_pkg::IDX_STATUS, 2'h0};
  localparam logic [11:0] A_MSK = {arfb_pkg::IDX_MASK, 2'h0};
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, sof_pulse = 1'b0, irq;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sck, word_select, rx_sd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] v;
  int failures = 0, n_tests = 0, cyc = 0;
  arfb_top arfb_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sck(sck),
    .word_select(word_select), .rx_sd(rx_sd), .sof_pulse(sof_pulse), .irq(irq));
  arfb_codec arfb_codec_i (.sck(sck), .word_select(word_select), .sd(rx_sd));
  // 200 MHz system clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // hang guard, well above the longest expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  // ***********************
  // checking and bus tasks
  // ***********************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d of %0d comparisons", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // both channels offered together, each dropped once taken; waits on bvalid
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata; rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // frame pulse; only its falling edge acts
  task automatic sof();
    sof_pulse <= 1'b1;
    repeat (4) @(posedge aclk);
    sof_pulse <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  // ***********************
  // expectation functions
  // ***********************
  function automatic logic [31:0] place(logic [31:0] d, int n, int w, bit j);
    return j ? d << (w - n) : d;
  endfunction
  // k-th 16-bit word read for buffers l and r
  function automatic logic [31:0] exp_rd(int k, logic [1:0] wc, logic [31:0] l, logic [31:0] r);
    logic [15:0] t[4];
    if (wc == arfb_pkg::CW_16) t = '{l[15:0], 16'h0, r[15:0], 16'h0};
    else if (wc == arfb_pkg::CW_24) t = '{l[15:0], 16'h0, {r[7:0], l[23:16]}, r[23:8]};
    else t = '{l[15:0], l[31:16], r[15:0], r[31:16]};
    return {16'h0, t[k]};
  endfunction
  // one left/right pair received and read out word by word
  task automatic rx_case(bit j, bit msb, logic [1:0] wc, int n);
    logic [31:0] l, r;
    int w;
    w = (wc == arfb_pkg::CW_16) ? 16 : (wc == arfb_pkg::CW_24) ? 24 : 32;
    l = $urandom & ~(32'hFFFFFFFF << n);
    r = $urandom & ~(32'hFFFFFFFF << n);
    wr(A_M0, 32'h0);
    wr(A_M0, {24'h0, j, msb, wc, 4'h5});
    wr(A_ST, 32'hFF);
    arfb_codec_i.chan(l, n, msb);
    fork
      arfb_codec_i.chan(r, n, msb);
    join_none
    repeat (20) @(posedge aclk);
    rd(A_ST); check("left_store_flag", v & 32'h1, 32'h1);
    check("irq_unmasked", 32'(irq), 32'h1);
    wr(A_MSK, 32'h0); check("irq_masked", 32'(irq), 32'h0);
    wr(A_MSK, 32'h1);
    wr(A_ST, 32'h1);
    l = place(l, n, w, j);
    r = place(r, n, w, j);
    rd(A_DAT); check("read0", v, exp_rd(0, wc, l, r));
    rd(A_ST); check("flag_after_read0", v & 32'h1, 32'(w == 32));
    wr(A_ST, 32'h1);
    rd(A_DAT); check("read1", v, exp_rd(1, wc, l, r));
    wait fork;
    arfb_codec_i.close();
    repeat (20) @(posedge aclk);
    rd(A_ST); check("right_store_flag", v & 32'h1, 32'h1);
    check("no_overrun", v & 32'h2, 32'h0);
    wr(A_ST, 32'h1);
    rd(A_DAT); check("read2", v, exp_rd(2, wc, l, r));
    rd(A_DAT); check("read3", v, exp_rd(3, wc, l, r));
  endtask
  // ***********************
  // main sequence
  // ***********************
  initial begin
    int n, k;
    logic [7:0] x;
    void'($urandom(32'h2EC5C7B3));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_M0); check("mode0_reset", v, 32'h0);
    check("mode0_rresp", 32'(rsp), 32'(arfb_pkg::RESP_OKAY));
    rd(A_M1); check("mode1_reset", v, 32'h0);
    check("irq_reset", 32'(irq), 32'h0);
    rd(12'hC58); check("unmapped_rresp", 32'(rsp), 32'(arfb_pkg::RESP_SLVERR));
    check("unmapped_rdata", v, 32'h0);
    wr(12'hC58, 32'h5A); check("unmapped_bresp", 32'(rsp), 32'(arfb_pkg::RESP_SLVERR));
    // random register round trips, receiver kept off
    for (int i = 0; i < 4; i++) begin
      x = $urandom;
      wr(A_M1, {24'h0, x}); rd(A_M1); check("mode1_rw", v, {24'h0, x});
      wr(A_M0, {24'h0, x & 8'hF2}); rd(A_M0); check("mode0_rw", v, {24'h0, x & 8'hF2});
      wr(A_MSK, {29'h0, x[2:0]}); rd(A_MSK); check("mask_rw", v, {29'h0, x[2:0]});
    end
    wr(A_M1, 32'h0);
    wr(A_MSK, 32'h1);
    // receiver disabled: no store, no flag
    wr(A_M0, 32'h31); wr(A_ST, 32'hFF);
    arfb_codec_i.chan(32'h1234, 16, 1'b0); arfb_codec_i.chan(32'h5678, 16, 1'b0); arfb_codec_i.close();
    repeat (20) @(posedge aclk);
    rd(A_ST); check("rx_off_flag", v & 32'h1, 32'h0);
    rx_case(1'b0, 1'b1, arfb_pkg::CW_16, 16);
    rx_case(1'b0, 1'b0, arfb_pkg::CW_24, 24);
    rx_case(1'b0, 1'b1, arfb_pkg::CW_32, 32);
    rx_case(1'b0, 1'b0, 2'h2, 32);
    rx_case(1'b1, 1'b1, arfb_pkg::CW_16, 8);
    rx_case(1'b0, 1'b0, arfb_pkg::CW_16, 8);
    rx_case(1'b1, 1'b0, arfb_pkg::CW_24, 16);
    // rate feedback, both count sources
    for (int s = 0; s < 2; s++) begin
      n = 4 + $urandom % 60;
      k = 1 + $urandom % (n - 1);
      wr(A_M0, 32'h09); wr(A_M1, 32'(s) << arfb_pkg::RATE_SRC_BIT); wr(A_ST, 32'hFF);
      sof(); arfb_codec_i.clocks(n, k); sof();
      rd(A_CAP); check("rate_count", v, 32'(s ? k : n));
      rd(A_ST); check("rate_flag", v & 32'h4, 32'h4);
      wr(A_CAP, $urandom); check("cap_write_bresp", 32'(rsp), 32'(arfb_pkg::RESP_OKAY));
      rd(A_CAP); check("cap_read_only", v, 32'(s ? k : n));
      sof(); rd(A_CAP); check("count_cleared", v, 32'h0);
    end
    wr(A_M0, 32'h01);
    sof(); arfb_codec_i.clocks(6, 6); sof();
    rd(A_CAP); check("rate_disabled", v, 32'h0);
    // clock enable low refuses the bus, then a reset in mid-run
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    check("ce_low_awready", 32'(s_axi_awready), 32'h0);
    check("ce_low_arready", 32'(s_axi_arready), 32'h0);
    ce <= 1'b1;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_MSK);
    check("mask_mid_reset", v, 32'h0);
    rd(A_M0);
    check("mode0_mid_reset", v, 32'h0);
    wrap_up();
  end
endmodule
